/* beac_pkg.sv */
// constants, register map and state codes of the byte nvm access controller
// assumes a 125 MHz system clock and an 8-bit special function register port
package beac_pkg;

    // store geometry
    localparam int          NVM_DEPTH       = 64;
    localparam int          NVM_WIDTH       = 8;
    localparam int          NVM_AW          = 6;

    // direct register addresses, {sector, address}
    localparam logic [8:0]  ADDR_LOCATION   = 9'h030;
    localparam logic [8:0]  ADDR_BYTE       = 9'h031;
    localparam logic [8:0]  ADDR_PTR_LOW    = 9'h032;
    localparam logic [8:0]  ADDR_PTR_HIGH   = 9'h033;
    localparam logic [8:0]  ADDR_INDIRECT   = 9'h034;
    // control register seen through the pointer pair, sector 1 address 40h
    localparam logic [15:0] PTR_CONTROL     = 16'h0140;

    // control field positions
    localparam int          CTRL_RD_BIT     = 0;
    localparam int          CTRL_FA_BIT     = 1;
    localparam int          CTRL_WR_BIT     = 2;
    localparam int          CTRL_PA_BIT     = 3;

    // values after reset
    localparam logic [7:0]  RST_LOCATION    = 8'h00;
    localparam logic [7:0]  RST_BYTE        = 8'h00;
    localparam logic [7:0]  RST_PTR         = 8'h00;
    localparam logic [7:0]  RST_RDATA       = 8'h00;

    // timing
    localparam int          CLK_PERIOD_NS   = 8;
    localparam int          SUB_PERIOD_NS   = 30518;
    localparam int          SUB_DIV_CYC     = SUB_PERIOD_NS / CLK_PERIOD_NS;
    localparam int          RD_LAT_CYC      = 2;
    localparam int          WR_SUB_TICKS    = 16;

    typedef enum logic [1:0] {
        BEAC_IDLE  = 2'b00,
        BEAC_READ  = 2'b01,
        BEAC_WRITE = 2'b10
    } beac_state_t;

endpackage : beac_pkg

/* beac_store.sv */
// non-volatile byte store held in flip-flops, one entry per location
// assumes one write strobe per byte; contents are not touched by reset
`timescale 1ns/1ps
module beac_store
    import beac_pkg::*;
#(
    parameter int DEPTH = NVM_DEPTH,
    parameter int WIDTH = NVM_WIDTH,
    parameter int AW    = NVM_AW
) (
    input  wire logic             clk,
    input  wire logic             we,
    input  wire logic [AW-1:0]    addr,
    input  wire logic [WIDTH-1:0] wdata,
    output logic      [WIDTH-1:0] rdata
);

    generate
        if (DEPTH > (1 << AW) || DEPTH < 1) begin : g_bad_depth
            $error("beac_store: depth does not fit the address width");
        end
    endgenerate

    logic [WIDTH-1:0] mem [DEPTH];

    // one entry per location, single byte per access
    genvar i;
    generate
        for (i = 0; i < DEPTH; i++) begin : g_entry
            always_ff @(posedge clk) begin
                if (we && (addr == AW'(i))) begin
                    mem[i] <= wdata;
                end
            end
        end
    endgenerate

    // selected byte
    assign rdata = mem[addr];

endmodule : beac_store

/* beac_top.sv */
// byte nvm access controller: location, byte, pointer and control registers
// assumes the cpu side drives one sfr access per cycle and keeps its own rules
//
// Summary of operation
// - sixty-four byte store reached only through location, byte and control registers.
// - each read or write moves one byte at the selected location.
// - location register keeps six bits, resets zero, upper two read zero.
// - byte register is eight-bit read-write, resets to zero.
// - write start launches only if program allow was already set.
// - write start stays one during the write, clears itself at the end.
// - read start launches only if fetch allow was already set.
// - read start clears at end with fetched byte in byte register.
// - fetched byte stays unchanged until the next read or write.
// - write duration timed by a sub clock timer, not the cpu clock.
// - write end sets the nvm flag and the multi-function flag.
// - vector only with all three enables set and stack not full.
// - servicing clears only the multi-function flag; software clears nvm flag.
// - reset clears all control bits and the pointer high byte.
`timescale 1ns/1ps
module beac_top
    import beac_pkg::*;
#(
    parameter int SUB_DIV   = SUB_DIV_CYC,
    parameter int WR_TICKS  = WR_SUB_TICKS
) (
    input  wire logic       clk,
    input  wire logic       srst,
    input  wire logic [8:0] sfr_addr,
    input  wire logic       sfr_wr,
    input  wire logic       sfr_rd,
    input  wire logic [7:0] sfr_wdata,
    output logic      [7:0] sfr_rdata,
    input  wire logic       global_irq_enable,
    input  wire logic       nvm_irq_enable,
    input  wire logic       mf_irq_enable,
    input  wire logic       stack_full,
    input  wire logic       irq_service,
    input  wire logic       nvm_irq_flag_clr,
    output logic            nvm_irq_flag,
    output logic            mf_irq_flag,
    output logic            irq_vector_req,
    output logic            nvm_busy
);

    generate
        if (SUB_DIV < 2 || SUB_DIV > 65536) begin : g_bad_div
            $error("beac_top: sub clock divider out of range");
        end
        if (WR_TICKS < 1 || WR_TICKS > 65535) begin : g_bad_ticks
            $error("beac_top: write tick count out of range");
        end
    endgenerate

    beac_state_t st_r, st_nxt;
    logic [15:0] cnt_r, cnt_nxt;
    logic [15:0] div_r, div_nxt;
    logic        sub_tick;
    logic [5:0]  location_r, location_nxt;
    logic [7:0]  byte_r, byte_nxt;
    logic [7:0]  ptr_low_r, ptr_low_nxt;
    logic [7:0]  ptr_high_r, ptr_high_nxt;
    logic        pa_r, pa_nxt;
    logic        wr_start_r, wr_start_nxt;
    logic        fa_r, fa_nxt;
    logic        rd_start_r, rd_start_nxt;
    logic        nvm_flag_r, nvm_flag_nxt;
    logic        mf_flag_r, mf_flag_nxt;
    logic [7:0]  rdata_r, rdata_nxt;
    logic        ctrl_sel;
    logic        ctrl_wr;
    logic        wr_done;
    logic        rd_done;
    logic        mem_we;
    logic [7:0]  mem_rdata;
    logic [7:0]  ctrl_val;

    // free running sub clock enable, the write timer's own time base
    always_comb begin
        div_nxt  = div_r + 16'h0001;
        sub_tick = (div_r == 16'(SUB_DIV - 1));
        if (sub_tick) begin
            div_nxt = 16'h0000;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            div_r <= 16'h0000;
        end else begin
            div_r <= div_nxt;
        end
    end

    // control register decode through the pointer pair
    assign ctrl_sel = ({ptr_high_r, ptr_low_r} == PTR_CONTROL);
    assign ctrl_wr  = sfr_wr && (sfr_addr == ADDR_INDIRECT) && ctrl_sel;
    assign ctrl_val = {4'h0, pa_r, wr_start_r, fa_r, rd_start_r};

    // end of cycle conditions
    assign wr_done  = (st_r == BEAC_WRITE) && sub_tick
                      && (cnt_r == 16'(WR_TICKS - 1));
    assign rd_done  = (st_r == BEAC_READ) && (cnt_r == 16'(RD_LAT_CYC - 1));
    assign mem_we   = wr_done;

    // sequencer and register next values
    always_comb begin
        st_nxt       = st_r;
        cnt_nxt      = cnt_r;
        location_nxt = location_r;
        byte_nxt     = byte_r;
        ptr_low_nxt  = ptr_low_r;
        ptr_high_nxt = ptr_high_r;
        pa_nxt       = pa_r;
        wr_start_nxt = wr_start_r;
        fa_nxt       = fa_r;
        rd_start_nxt = rd_start_r;
        if (sfr_wr && sfr_addr == ADDR_LOCATION) begin
            location_nxt = sfr_wdata[5:0];
        end
        if (sfr_wr && sfr_addr == ADDR_BYTE) begin
            byte_nxt = sfr_wdata;
        end
        if (sfr_wr && sfr_addr == ADDR_PTR_LOW) begin
            ptr_low_nxt = sfr_wdata;
        end
        if (sfr_wr && sfr_addr == ADDR_PTR_HIGH) begin
            ptr_high_nxt = sfr_wdata;
        end
        if (ctrl_wr) begin
            pa_nxt = sfr_wdata[CTRL_PA_BIT];
            fa_nxt = sfr_wdata[CTRL_FA_BIT];
        end
        case (st_r)
            BEAC_IDLE: begin
                cnt_nxt = 16'h0000;
                if (ctrl_wr && sfr_wdata[CTRL_WR_BIT] && pa_r) begin
                    wr_start_nxt = 1'b1;
                    st_nxt       = BEAC_WRITE;
                end else if (ctrl_wr && sfr_wdata[CTRL_RD_BIT] && fa_r) begin
                    rd_start_nxt = 1'b1;
                    st_nxt       = BEAC_READ;
                end
            end
            BEAC_READ: begin
                cnt_nxt = cnt_r + 16'h0001;
                if (rd_done) begin
                    byte_nxt     = mem_rdata;
                    rd_start_nxt = 1'b0;
                    st_nxt       = BEAC_IDLE;
                end
            end
            BEAC_WRITE: begin
                wr_start_nxt = 1'b1;
                if (sub_tick) begin
                    cnt_nxt = cnt_r + 16'h0001;
                end
                if (wr_done) begin
                    wr_start_nxt = 1'b0;
                    st_nxt       = BEAC_IDLE;
                end
            end
            default: begin
                st_nxt       = BEAC_IDLE;
                wr_start_nxt = 1'b0;
                rd_start_nxt = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            st_r       <= BEAC_IDLE;
            cnt_r      <= 16'h0000;
            location_r <= RST_LOCATION[5:0];
            byte_r     <= RST_BYTE;
            ptr_low_r  <= RST_PTR;
            ptr_high_r <= RST_PTR;
            pa_r       <= 1'b0;
            wr_start_r <= 1'b0;
            fa_r       <= 1'b0;
            rd_start_r <= 1'b0;
        end else begin
            st_r       <= st_nxt;
            cnt_r      <= cnt_nxt;
            location_r <= location_nxt;
            byte_r     <= byte_nxt;
            ptr_low_r  <= ptr_low_nxt;
            ptr_high_r <= ptr_high_nxt;
            pa_r       <= pa_nxt;
            wr_start_r <= wr_start_nxt;
            fa_r       <= fa_nxt;
            rd_start_r <= rd_start_nxt;
        end
    end

    // write-done flags, set wins over clear
    always_comb begin
        nvm_flag_nxt = (nvm_flag_r && !nvm_irq_flag_clr) || wr_done;
        mf_flag_nxt  = (mf_flag_r && !irq_service) || wr_done;
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            nvm_flag_r <= 1'b0;
            mf_flag_r  <= 1'b0;
        end else begin
            nvm_flag_r <= nvm_flag_nxt;
            mf_flag_r  <= mf_flag_nxt;
        end
    end

    // registered read port, upper location bits read zero
    always_comb begin
        rdata_nxt = rdata_r;
        if (sfr_rd) begin
            case (sfr_addr)
                ADDR_LOCATION: rdata_nxt = {2'b00, location_r};
                ADDR_BYTE:     rdata_nxt = byte_r;
                ADDR_PTR_LOW:  rdata_nxt = ptr_low_r;
                ADDR_PTR_HIGH: rdata_nxt = ptr_high_r;
                ADDR_INDIRECT: rdata_nxt = ctrl_sel ? ctrl_val : 8'h00;
                default:       rdata_nxt = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            rdata_r <= RST_RDATA;
        end else begin
            rdata_r <= rdata_nxt;
        end
    end

    beac_store #(
        .DEPTH (NVM_DEPTH),
        .WIDTH (NVM_WIDTH),
        .AW    (NVM_AW)
    ) u_store (
        .clk   (clk),
        .we    (mem_we),
        .addr  (location_r),
        .wdata (byte_r),
        .rdata (mem_rdata)
    );

    // outputs
    assign sfr_rdata      = rdata_r;
    assign nvm_irq_flag   = nvm_flag_r;
    assign mf_irq_flag    = mf_flag_r;
    assign nvm_busy       = (st_r != BEAC_IDLE);
    assign irq_vector_req = mf_flag_r && nvm_flag_r && global_irq_enable
                            && nvm_irq_enable && mf_irq_enable && !stack_full;

    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    chk_wr_gate: assert property (
        (st_r == BEAC_IDLE && ctrl_wr && sfr_wdata[CTRL_WR_BIT] && !pa_r)
        |=> (st_r != BEAC_WRITE) && !wr_start_r)
        else $error("write launched without program allow");

    chk_wr_hold: assert property (
        (st_r == BEAC_WRITE) |-> wr_start_r && nvm_busy)
        else $error("write start dropped during write");

    chk_wr_end: assert property (
        wr_done |=> !wr_start_r && (st_r == BEAC_IDLE))
        else $error("write start not cleared at write end");

    chk_rd_gate: assert property (
        (st_r == BEAC_IDLE && ctrl_wr && sfr_wdata[CTRL_RD_BIT]
         && !sfr_wdata[CTRL_WR_BIT] && !fa_r)
        |=> !rd_start_r)
        else $error("read launched without fetch allow");

    chk_rd_end: assert property (
        $rose(rd_start_r) |-> ##2 !rd_start_r && (byte_r == $past(mem_rdata))
    ) else $error("read did not finish with fetched byte");

    chk_byte_hold: assert property (
        (st_r == BEAC_IDLE && !(sfr_wr && sfr_addr == ADDR_BYTE))
        |=> $stable(byte_r))
        else $error("byte register changed without an access");

    chk_loc_upper: assert property (
        (sfr_rd && sfr_addr == ADDR_LOCATION) |=> (sfr_rdata[7:6] == 2'b00))
        else $error("upper location bits not zero");

    chk_done_flags: assert property (
        wr_done |=> nvm_flag_r && mf_flag_r)
        else $error("write end did not set both flags");

    chk_vector_gate: assert property (
        irq_vector_req |-> global_irq_enable && !stack_full && mf_flag_r)
        else $error("vector raised while blocked");

    chk_service_clr: assert property (
        (irq_service && !wr_done && nvm_flag_r && !nvm_irq_flag_clr)
        |=> !mf_flag_r && nvm_flag_r)
        else $error("servicing cleared the wrong flag");

    chk_reset_state: assert property (
        disable iff (1'b0) srst |=> (ptr_high_r == 8'h00) && (ctrl_val == 8'h00))
        else $error("reset left control or pointer high set");

    cov_write: cover property (wr_done ##1 (st_r == BEAC_IDLE) && !wr_start_r);
    cov_read: cover property ($rose(rd_start_r) ##2 !rd_start_r);
    cov_vector: cover property (irq_vector_req ##1 irq_service);
    cov_blocked: cover property (ctrl_wr && sfr_wdata[CTRL_WR_BIT] && !pa_r);

endmodule : beac_top

/* test_byte_eeprom_access_controller.sv */
// self-checking bench for the byte nvm access controller, with an associative-array store model
// assumes beac_pkg is compiled first; the bench drives every port of beac_top itself
`timescale 1ns/1ps
module test_byte_eeprom_access_controller;
    import beac_pkg::*;

    logic        clk;
    logic        srst;
    logic [8:0]  sfr_addr;
    logic        sfr_wr;
    logic        sfr_rd;
    logic [7:0]  sfr_wdata;
    logic [7:0]  sfr_rdata;
    logic        global_irq_enable;
    logic        nvm_irq_enable;
    logic        mf_irq_enable;
    logic        stack_full;
    logic        irq_service;
    logic        nvm_irq_flag_clr;
    logic        nvm_irq_flag;
    logic        mf_irq_flag;
    logic        irq_vector_req;
    logic        nvm_busy;
    int          fails;
    int          total_checks;
    int          cycles;
    int          mem[int];
    int          wq[$];
    logic [15:0] rnd;
    logic [7:0]  v;

    // short sub tick and write length keep each write to a few clocks
    beac_top #(.SUB_DIV(4), .WR_TICKS(2)) i_beac_top (
        .clk               (clk),
        .srst              (srst),
        .sfr_addr          (sfr_addr),
        .sfr_wr            (sfr_wr),
        .sfr_rd            (sfr_rd),
        .sfr_wdata         (sfr_wdata),
        .sfr_rdata         (sfr_rdata),
        .global_irq_enable (global_irq_enable),
        .nvm_irq_enable    (nvm_irq_enable),
        .mf_irq_enable     (mf_irq_enable),
        .stack_full        (stack_full),
        .irq_service       (irq_service),
        .nvm_irq_flag_clr  (nvm_irq_flag_clr),
        .nvm_irq_flag      (nvm_irq_flag),
        .mf_irq_flag       (mf_irq_flag),
        .irq_vector_req    (irq_vector_req),
        .nvm_busy          (nvm_busy)
    );

    // 125 mhz clock
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr

    task automatic summarize;
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : summarize

    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        total_checks++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk

    // one register write, strobe left high for a back-to-back follower
    task automatic bus_wr(input logic [8:0] a, input logic [7:0] d);
        sfr_addr  <= a;
        sfr_wdata <= d;
        sfr_wr    <= 1'b1;
        sfr_rd    <= 1'b0;
        @(posedge clk);
    endtask : bus_wr

    task automatic idle;
        sfr_wr <= 1'b0;
        sfr_rd <= 1'b0;
        @(posedge clk);
    endtask : idle

    // read returns at an edge holding the settled read data of the cycle before
    task automatic bus_rd(input logic [8:0] a, output logic [7:0] d);
        sfr_addr <= a;
        sfr_wr   <= 1'b0;
        sfr_rd   <= 1'b1;
        @(posedge clk);
        sfr_rd <= 1'b0;
        repeat (2) @(posedge clk);
        d = sfr_rdata;
    endtask : bus_rd

    task automatic pulse(input int which);
        if (which == 0) irq_service <= 1'b1;
        else nvm_irq_flag_clr <= 1'b1;
        @(posedge clk);
        irq_service      <= 1'b0;
        nvm_irq_flag_clr <= 1'b0;
        @(posedge clk);
    endtask : pulse

    // full write with polling, flag and vector checks; on forces all enables
    task automatic do_write(input logic [5:0] a, input logic [7:0] d, input logic on);
        int         n;
        logic [7:0] c;
        logic       ev;
        rnd = lfsr(rnd);
        global_irq_enable <= 1'b0;
        nvm_irq_enable    <= on | (|rnd[3:2]);
        mf_irq_enable     <= on | (|rnd[7:6]);
        stack_full        <= ~on & (&rnd[5:4]);
        bus_wr(ADDR_LOCATION, {2'b00, a});
        bus_wr(ADDR_BYTE, d);
        bus_wr(ADDR_INDIRECT, 8'h08);
        bus_wr(ADDR_INDIRECT, 8'h0c);
        global_irq_enable <= on | (|rnd[1:0]);
        idle();
        idle();
        chk({7'h0, nvm_busy}, 8'h01, "busy during write");
        bus_rd(ADDR_INDIRECT, c);
        chk(c, 8'h0c, "write start held");
        n = 0;
        while (c[CTRL_WR_BIT] === 1'b1 && n < 20) begin
            bus_rd(ADDR_INDIRECT, c);
            n++;
        end
        chk(c, 8'h08, "write start self clear");
        chk({7'h0, nvm_busy}, 8'h00, "idle after write");
        mem[a] = d;
        wq.push_back(a);
        ev = global_irq_enable & nvm_irq_enable & mf_irq_enable & ~stack_full;
        chk({7'h0, nvm_irq_flag}, 8'h01, "nvm flag set");
        chk({7'h0, mf_irq_flag}, 8'h01, "mf flag set");
        chk({7'h0, irq_vector_req}, {7'h0, ev}, "vector request");
        pulse(0);
        chk({7'h0, mf_irq_flag}, 8'h00, "service clears mf");
        chk({7'h0, nvm_irq_flag}, 8'h01, "service keeps nvm");
        chk({7'h0, irq_vector_req}, 8'h00, "vector drops");
        pulse(1);
        chk({7'h0, nvm_irq_flag}, 8'h00, "software clears nvm");
    endtask : do_write

    task automatic do_read(input logic [5:0] a);
        int         n;
        logic [7:0] c;
        bus_wr(ADDR_LOCATION, {2'b00, a});
        bus_wr(ADDR_INDIRECT, 8'h02);
        bus_wr(ADDR_INDIRECT, 8'h03);
        c = 8'h01;
        n = 0;
        while (c[CTRL_RD_BIT] === 1'b1 && n < 20) begin
            bus_rd(ADDR_INDIRECT, c);
            n++;
        end
        chk(c, 8'h02, "read start self clear");
        bus_rd(ADDR_BYTE, c);
        chk(c, 8'(mem[a]), "fetched byte");
    endtask : do_read

    // hang guard, a few thousand cycles above the expected run
    always @(posedge clk) begin
        cycles++;
        if (cycles == 6000) begin
            fails++;
            $display("CHECK FAILED %0t: run did not finish", $time);
            summarize();
        end
    end

    // main sequence
    initial begin
        srst              = 1'b1;
        sfr_addr          = '0;
        sfr_wr            = 1'b0;
        sfr_rd            = 1'b0;
        sfr_wdata         = '0;
        global_irq_enable = 1'b0;
        nvm_irq_enable    = 1'b0;
        mf_irq_enable     = 1'b0;
        stack_full        = 1'b0;
        irq_service       = 1'b0;
        nvm_irq_flag_clr  = 1'b0;
        fails             = 0;
        total_checks      = 0;
        cycles            = 0;
        rnd               = 16'hb19d;
        repeat (8) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        bus_rd(ADDR_LOCATION, v);
        chk(v, RST_LOCATION, "location reset");
        bus_rd(ADDR_BYTE, v);
        chk(v, RST_BYTE, "byte reset");
        bus_rd(ADDR_PTR_HIGH, v);
        chk(v, RST_PTR, "pointer high reset");
        bus_wr(ADDR_PTR_LOW, PTR_CONTROL[7:0]);
        bus_wr(ADDR_PTR_HIGH, PTR_CONTROL[15:8]);
        bus_rd(ADDR_INDIRECT, v);
        chk(v, 8'h00, "control reset");
        bus_wr(ADDR_LOCATION, 8'hff);
        bus_rd(ADDR_LOCATION, v);
        chk(v, 8'h3f, "location upper bits");
        rnd = lfsr(rnd);
        bus_wr(ADDR_BYTE, rnd[7:0]);
        bus_rd(ADDR_BYTE, v);
        chk(v, rnd[7:0], "byte read-write");
        bus_wr(ADDR_INDIRECT, 8'h04);
        bus_rd(ADDR_INDIRECT, v);
        chk(v, 8'h00, "write start w/o allow");
        bus_wr(ADDR_INDIRECT, 8'h01);
        bus_rd(ADDR_INDIRECT, v);
        chk(v, 8'h00, "read start w/o allow");
        bus_wr(ADDR_PTR_LOW, 8'h41);
        bus_wr(ADDR_INDIRECT, 8'h0a);
        bus_rd(ADDR_INDIRECT, v);
        chk(v, 8'h00, "wrong pointer");
        bus_wr(ADDR_PTR_LOW, 8'h40);
        bus_rd(ADDR_INDIRECT, v);
        chk(v, 8'h00, "wrong pointer ignored");
        bus_rd(9'h1ff, v);
        chk(v, 8'h00, "unmapped address");
        // writes at both ends of the store and at random places
        for (int i = 0; i < 5; i++) begin
            rnd = lfsr(rnd);
            do_write((i == 0) ? 6'h00 : (i == 1) ? 6'h3f : rnd[5:0], rnd[15:8], i == 0);
        end
        foreach (wq[k]) begin
            do_read(6'(wq[k]));
        end
        bus_wr(ADDR_LOCATION, 8'h15);
        bus_rd(ADDR_BYTE, v);
        chk(v, 8'(mem[wq[$]]), "fetched byte holds");
        // reset in mid-run clears control and pointer high
        bus_wr(ADDR_INDIRECT, 8'h0a);
        idle();
        srst <= 1'b1;
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        bus_rd(ADDR_PTR_HIGH, v);
        chk(v, 8'h00, "pointer high after reset");
        bus_wr(ADDR_PTR_LOW, PTR_CONTROL[7:0]);
        bus_wr(ADDR_PTR_HIGH, PTR_CONTROL[15:8]);
        bus_rd(ADDR_INDIRECT, v);
        chk(v, 8'h00, "control after reset");
        summarize();
    end

endmodule : test_byte_eeprom_access_controller
